// ### far_device_model.sv
`timescale 1ns/100ps
`default_nettype none
// far device: one acknowledge pulse a set time after each latch strobe that ends while answer_en_i is high
module far_device_model #(
    parameter int REPLY_CLKS = 14,
    parameter int PULSE_CLKS = 4
) (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic latch_strobe_i,
    input  wire logic answer_en_i,
    output logic      ack_o
);
    logic strobe_d_reg;
    int   count_reg;
    // reply counted from the strobe end so it lands after the longest hold; answer_en_i low never replies
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_d_reg <= 1'b0;
            count_reg <= 0;
            ack_o <= 1'b0;
        end else begin
            strobe_d_reg <= latch_strobe_i;
            if (strobe_d_reg && !latch_strobe_i && answer_en_i) count_reg <= 1;
            else if (count_reg == REPLY_CLKS + PULSE_CLKS) count_reg <= 0;
            else if (count_reg != 0) count_reg <= count_reg + 1;
            ack_o <= (count_reg >= REPLY_CLKS) && (count_reg < REPLY_CLKS + PULSE_CLKS);
        end
    end
endmodule
`default_nettype wire

// ### parallel_master_port_control.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "port_control_params.svh"
module parallel_master_port_control
    import port_control_pkg::*;
#(
    parameter int QUARTER_CLKS    = 2,
    parameter int TIMEOUT_CLKS    = 256
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        txn_start_i,
    input  wire logic        txn_write_i,
    input  wire logic [1:0]  txn_byte_en_i,
    input  wire logic        txn_ack_i,
    output logic             busy_o,
    output logic             irq_o,
    output logic             latch_strobe_o,
    output logic [23:0]      reserved_space_last_addr_o,
    output logic             write_enable_strobe_pin_o,
    output logic             write_enable_strobe_pin_oe_o,
    output logic             read_write_strobe_pin_o,
    output logic             read_write_strobe_pin_oe_o,
    output logic             high_byte_enable_pin_o,
    output logic             high_byte_enable_pin_oe_o,
    output logic             low_byte_enable_pin_o,
    output logic             low_byte_enable_pin_oe_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    seq_state_t  state_reg;
    logic [15:0] count_reg;
    logic        error_reg;
    logic        timeout_reg;
    logic [7:0]  reserved_space_upper_address_reg;
    logic [3:0]  pin_enable_reg;
    logic [1:0]  latch_strobe_wait_select_reg;
    logic        latch_hold_wait_select_reg;
    logic [2:0]  irq_status_reg;
    logic [2:0]  irq_mask_reg;
    logic        write_reg;
    logic [1:0]  byte_en_reg;
    logic        ack_meta_reg;
    logic        ack_sync_reg;
    logic        wr_fire;
    logic        rd_fire;
    logic        start_ok;
    logic        start_bad;
    logic        done_evt;
    logic        tmo_evt;
    logic        status_w1c;
    logic [2:0]  irq_set;
    logic [15:0] wdata16;
    logic [31:0] rdata_next;

    // strobe length in clocks: (2*sel+1) half cycles, two quarters per half
    function automatic logic [15:0] strobe_clks(input logic [1:0] sel);
        strobe_clks = 16'(({2'h0, sel} * 4'h2 + 4'h1) * 2 * QUARTER_CLKS);
    endfunction

    // hold length in clocks
    function automatic logic [15:0] hold_clks(input logic sel);
        hold_clks = 16'((sel ? `HOLD_LONG_QUARTERS : `HOLD_SHORT_QUARTERS) * QUARTER_CLKS);
    endfunction

    assign wr_fire   = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    assign rd_fire   = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    assign start_ok  = txn_start_i && state_reg == ST_IDLE;
    assign start_bad = txn_start_i && state_reg != ST_IDLE;
    assign done_evt  = state_reg == ST_DATA && ack_sync_reg;
    assign tmo_evt   = state_reg == ST_DATA && !ack_sync_reg && count_reg == 16'h0001;
    assign wdata16   = s_axi_wdata[15:0];
    // write to the status word with its upper byte lane open: the only way to clear the error and timeout flags
    assign status_w1c = wr_fire && s_axi_awaddr == `OFS_STATUS_RESERVED && s_axi_wstrb[1];
    assign irq_set   = {tmo_evt, start_bad, done_evt};

    // ----------------------------------------
    // acknowledge pin synchroniser
    // ----------------------------------------
    // the pin belongs to the far device, so it is retimed before use
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end else if (ce_i) begin
            ack_meta_reg <= txn_ack_i;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    // ----------------------------------------
    // transaction sequencer
    // ----------------------------------------
    // busy tracking
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg   <= ST_IDLE;
            count_reg   <= 16'h0000;
            write_reg   <= 1'b0;
            byte_en_reg <= 2'h0;
        end else if (ce_i) begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_ok) begin
                        state_reg   <= ST_STROBE;
                        count_reg   <= strobe_clks(latch_strobe_wait_select_reg);
                        write_reg   <= txn_write_i;
                        byte_en_reg <= txn_byte_en_i;
                    end
                end
                ST_STROBE: begin
                    if (count_reg == 16'h0001) begin
                        state_reg <= ST_HOLD;
                        count_reg <= hold_clks(latch_hold_wait_select_reg);
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                ST_HOLD: begin
                    if (count_reg == 16'h0001) begin
                        state_reg <= ST_DATA;
                        count_reg <= 16'(TIMEOUT_CLKS);
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                ST_DATA: begin
                    if (done_evt || tmo_evt) begin
                        state_reg <= ST_IDLE;
                        count_reg <= 16'h0000;
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // error flag, set beats a write-one clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            error_reg <= 1'b0;
        end else if (ce_i) begin
            if (start_bad) begin
                error_reg <= 1'b1;
            end else if (status_w1c && wdata16[`BIT_ERROR]) begin
                error_reg <= 1'b0;
            end
        end
    end

    // timeout flag, set beats a write-one clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            timeout_reg <= 1'b0;
        end else if (ce_i) begin
            if (tmo_evt) begin
                timeout_reg <= 1'b1;
            end else if (status_w1c && wdata16[`BIT_TIMEOUT]) begin
                timeout_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            reserved_space_upper_address_reg <= 8'h00;
            pin_enable_reg                   <= 4'h0;
            latch_strobe_wait_select_reg     <= 2'h0;
            latch_hold_wait_select_reg       <= 1'b0;
            irq_mask_reg                     <= `RESET_IRQ;
        end else if (ce_i && wr_fire) begin
            if (s_axi_awaddr == `OFS_STATUS_RESERVED && s_axi_wstrb[0]) begin
                reserved_space_upper_address_reg <= wdata16[7:0];
            end
            if (s_axi_awaddr == `OFS_STROBE_WAIT && s_axi_wstrb[1]) begin
                pin_enable_reg               <= wdata16[`BIT_WR_PIN_EN:`BIT_BE0_PIN_EN];
                latch_strobe_wait_select_reg <= wdata16[`BIT_STROBE_WAIT_HI:`BIT_STROBE_WAIT_LO];
                latch_hold_wait_select_reg   <= wdata16[`BIT_HOLD_WAIT];
            end
            if (s_axi_awaddr == `OFS_IRQ_MASK && s_axi_wstrb[0]) begin
                irq_mask_reg <= s_axi_wdata[2:0];
            end
        end
    end

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    // sticky events; a new event in the clearing cycle survives
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_status_reg <= `RESET_IRQ;
            irq_o          <= 1'b0;
        end else if (ce_i) begin
            if (wr_fire && s_axi_awaddr == `OFS_IRQ_STATUS && s_axi_wstrb[0]) begin
                irq_status_reg <= (irq_status_reg & ~s_axi_wdata[2:0]) | irq_set;
            end else begin
                irq_status_reg <= irq_status_reg | irq_set;
            end
            irq_o <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (s_axi_araddr)
            `OFS_STATUS_RESERVED: rdata_next = {16'h0000, state_reg != ST_IDLE, 1'b0, error_reg, timeout_reg,
                                                4'h0, reserved_space_upper_address_reg};
            `OFS_STROBE_WAIT:     rdata_next = {16'h0000, pin_enable_reg, 1'b0, latch_strobe_wait_select_reg,
                                                latch_hold_wait_select_reg, 8'h00};
            `OFS_IRQ_STATUS:      rdata_next = {29'h0, irq_status_reg};
            `OFS_IRQ_MASK:        rdata_next = {29'h0, irq_mask_reg};
            default:              rdata_next = 32'h0000_0000;
        endcase
    end

    // write channel: address and data taken together, answer one cycle later
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_RESP_OKAY;
        end else if (ce_i) begin
            s_axi_awready <= wr_fire;
            s_axi_wready  <= wr_fire;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (s_axi_awaddr[1:0] == 2'h0) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel; unmapped offsets read zero with slverr
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
        end else if (ce_i) begin
            s_axi_arready <= rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdata_next;
                s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pins and port outputs
    // ----------------------------------------
    // registered so every pin changes cleanly on the clock edge
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o                       <= 1'b0;
            latch_strobe_o               <= 1'b0;
            reserved_space_last_addr_o   <= `TOP_OF_SPACE;
            write_enable_strobe_pin_o    <= 1'b0;
            write_enable_strobe_pin_oe_o <= 1'b0;
            read_write_strobe_pin_o      <= 1'b0;
            read_write_strobe_pin_oe_o   <= 1'b0;
            high_byte_enable_pin_o       <= 1'b0;
            high_byte_enable_pin_oe_o    <= 1'b0;
            low_byte_enable_pin_o        <= 1'b0;
            low_byte_enable_pin_oe_o     <= 1'b0;
        end else if (ce_i) begin
            busy_o                       <= state_reg != ST_IDLE && !(done_evt || tmo_evt) || start_ok;
            latch_strobe_o               <= state_reg == ST_STROBE && count_reg != 16'h0001 || start_ok;
            // last address of the reserved space
            reserved_space_last_addr_o   <= (reserved_space_upper_address_reg == 8'h00) ? `TOP_OF_SPACE :
                                            24'({reserved_space_upper_address_reg, 16'h0000} - 24'h000001);
            // pin ownership from the enable bits
            write_enable_strobe_pin_oe_o <= pin_enable_reg[3];
            read_write_strobe_pin_oe_o   <= pin_enable_reg[2];
            high_byte_enable_pin_oe_o    <= pin_enable_reg[1];
            low_byte_enable_pin_oe_o     <= pin_enable_reg[0];
            write_enable_strobe_pin_o    <= state_reg == ST_DATA && !(done_evt || tmo_evt) ||
                                            state_reg == ST_HOLD && count_reg == 16'h0001;
            read_write_strobe_pin_o      <= write_reg;
            high_byte_enable_pin_o       <= byte_en_reg[1];
            low_byte_enable_pin_o        <= byte_en_reg[0];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence idle_start_s;
        ce_i && start_ok;
    endsequence

    busy_follows_a: assert property (@(posedge clock_i) disable iff (rst_i)
        idle_start_s |=> busy_o)
        else $error("busy not raised after start");
    error_sets_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ce_i && start_bad |=> error_reg && irq_status_reg[`IRQ_BIT_ERROR])
        else $error("illegal start did not set error");
    timeout_sets_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ce_i && tmo_evt |=> timeout_reg && state_reg == ST_IDLE)
        else $error("timeout flag missing");
    top_address_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ce_i && reserved_space_upper_address_reg == 8'h00 |=> reserved_space_last_addr_o == `TOP_OF_SPACE)
        else $error("zero field not mapped to top");
    pin_enable_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ce_i |=> {write_enable_strobe_pin_oe_o, read_write_strobe_pin_oe_o, high_byte_enable_pin_oe_o,
                  low_byte_enable_pin_oe_o} == $past(pin_enable_reg))
        else $error("pin enable does not follow register");
    strobe_length_a: assert property (@(posedge clock_i) disable iff (rst_i)
        idle_start_s |=> count_reg == strobe_clks($past(latch_strobe_wait_select_reg)))
        else $error("latch strobe length wrong");
    hold_length_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ce_i && state_reg == ST_STROBE && count_reg == 16'h0001 |=>
            state_reg == ST_HOLD && count_reg == hold_clks(latch_hold_wait_select_reg))
        else $error("hold length wrong");
    bus_answer_a: assert property (@(posedge clock_i) disable iff (rst_i)
        ce_i && wr_fire |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write not answered next cycle");

endmodule
`default_nettype wire

// ### parallel_master_port_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module parallel_master_port_control_bench;
    localparam int Q = 2;
    localparam int TMO = 32;
    typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] r; logic [23:0] last; logic [3:0] oe;} row_t;
    logic clock_i = 1'b0, rst_i = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, start = 1'b0, twrite = 1'b0, ack, answer = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] ben = 2'h0, bresp, rresp, resp;
    logic awready, wready, bvalid, arready, rvalid, busy, irq, strobe;
    logic [23:0] last;
    wire [3:0] oe, pin;
    logic [31:0] rd;
    int err_count = 0, num_checks = 0, n, t0, t1, act;
    row_t rows[8] = '{
        '{4'h0, 32'h00000000, 32'h00000000, 24'hffffff, 4'h0}, '{4'h0, 32'hffff00ff, 32'h000000ff, 24'hfeffff, 4'h0},
        '{4'h0, 32'h00000001, 32'h00000001, 24'h00ffff, 4'h0}, '{4'h4, 32'h0000ffff, 32'h0000f700, 24'h00ffff, 4'hf},
        '{4'h4, 32'h00008000, 32'h00008000, 24'h00ffff, 4'h8}, '{4'h4, 32'h00004200, 32'h00004200, 24'h00ffff, 4'h4},
        '{4'h4, 32'h00002400, 32'h00002400, 24'h00ffff, 4'h2}, '{4'h4, 32'h00001000, 32'h00001000, 24'h00ffff, 4'h1}};
    always #4 clock_i = ~clock_i;
    parallel_master_port_control #(.QUARTER_CLKS(Q), .TIMEOUT_CLKS(TMO)) i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .txn_start_i(start),
        .txn_write_i(twrite), .txn_byte_en_i(ben), .txn_ack_i(ack), .busy_o(busy), .irq_o(irq),
        .latch_strobe_o(strobe), .reserved_space_last_addr_o(last),
        .write_enable_strobe_pin_o(pin[3]), .write_enable_strobe_pin_oe_o(oe[3]),
        .read_write_strobe_pin_o(pin[2]), .read_write_strobe_pin_oe_o(oe[2]),
        .high_byte_enable_pin_o(pin[1]), .high_byte_enable_pin_oe_o(oe[1]),
        .low_byte_enable_pin_o(pin[0]), .low_byte_enable_pin_oe_o(oe[0]));
    far_device_model i_far (.clock_i(clock_i), .rst_i(rst_i), .latch_strobe_i(strobe),
                            .answer_en_i(answer), .ack_o(ack));
    task end_of_test;
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // address and data offered together, each dropped at its own ready, response taken at bvalid
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clock_i);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!done) begin
            @(posedge clock_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                done = 1'b1;
                resp = bresp;
                bready <= 1'b0;
            end
        end
    endtask
    task rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic done;
        done = 1'b0;
        @(posedge clock_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(posedge clock_i);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                done = 1'b1;
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
            end
        end
        chk(rd, exp);
        chk(resp, 2'h0);
    endtask
    task txn;
        @(posedge clock_i);
        start <= 1'b1; twrite <= ~twrite; ben <= ben + 2'h1;
        @(posedge clock_i);
        start <= 1'b0;
    endtask
    // strobe length in clocks, then clocks from strobe end to idle
    task measure(output int len, output int tail);
        len = 0;
        tail = 0;
        act = 0;
        while (strobe !== 1'b1) @(negedge clock_i);
        while (strobe === 1'b1) begin @(negedge clock_i); len++; end
        // act counts clocks with the write/enable strobe pin driven high
        while (busy === 1'b1) begin
            @(negedge clock_i);
            tail++;
            if (pin[3] === 1'b1) act++;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        chk(last, 24'hffffff);
        chk({busy, irq, oe}, 6'h00);
        for (int i = 0; i < 4; i++) rd_chk(4'(4 * i), 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].r);
            chk(last, rows[i].last);
            chk(oe, rows[i].oe);
        end
        wr(4'h2, 32'h0);
        chk(resp, 2'h2);
        wr(4'hc, 32'h7);
        chk(resp, 2'h0);
        for (int s = 0; s < 4; s++) begin
            wr(4'h4, 32'hf000 | (s << 9));
            txn();
            measure(n, t0);
            chk(n, (2 * s + 1) * 2 * Q);
            chk(pin, {1'b0, twrite, ben});
            rd_chk(4'h8, 32'h1);
            wr(4'h8, 32'h1);
        end
        txn();
        txn();
        chk(busy, 1'b1);
        rd_chk(4'h0, 32'h0000a001);
        chk(irq, 1'b1);
        while (busy === 1'b1) @(negedge clock_i);
        rd_chk(4'h8, 32'h3);
        wr(4'h0, 32'h00002001);
        rd_chk(4'h0, 32'h00000001);
        wr(4'h8, 32'h3);
        repeat (3) @(posedge clock_i);
        chk(irq, 1'b0);
        answer <= 1'b0;
        for (int h = 0; h < 2; h++) begin
            wr(4'h4, 32'hf000 | (h << 8));
            txn();
            measure(n, t1);
            if (h == 0) t0 = t1;
            chk(act, TMO);
            chk(pin, {1'b0, twrite, ben});
            rd_chk(4'h0, 32'h00001001);
            rd_chk(4'h8, 32'h4);
            wr(4'hc, 32'h0);
            repeat (3) @(posedge clock_i);
            chk(irq, 1'b0);
            wr(4'hc, 32'h4);
            repeat (3) @(posedge clock_i);
            chk(irq, 1'b1);
            wr(4'h8, 32'h4);
            wr(4'h0, 32'h00001001);
            rd_chk(4'h0, 32'h00000001);
        end
        chk(t1 - t0, 4 * Q);
        repeat (3) @(posedge clock_i);
        chk(irq, 1'b0);
        // mid-run reset: everything back to its reset value at once
        rst_i <= 1'b1;
        @(posedge clock_i);
        rst_i <= 1'b0;
        chk({busy, irq, oe, pin}, 10'h000);
        chk(last, 24'hffffff);
        for (int i = 0; i < 2; i++) rd_chk(4'(4 * i), 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire

// ### port_control_params.svh
`ifndef PORT_CONTROL_PARAMS_SVH
`define PORT_CONTROL_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_STATUS_RESERVED  4'h0
`define OFS_STROBE_WAIT      4'h4
`define OFS_IRQ_STATUS       4'h8
`define OFS_IRQ_MASK         4'hc

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_BUSY             15
`define BIT_ERROR            13
`define BIT_TIMEOUT          12
`define BIT_WR_PIN_EN        15
`define BIT_RD_PIN_EN        14
`define BIT_BE1_PIN_EN       13
`define BIT_BE0_PIN_EN       12
`define BIT_STROBE_WAIT_HI   10
`define BIT_STROBE_WAIT_LO   9
`define BIT_HOLD_WAIT        8
`define IRQ_BIT_DONE         0
`define IRQ_BIT_ERROR        1
`define IRQ_BIT_TIMEOUT      2

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RESET_16             16'h0000
`define RESET_IRQ            3'h0
`define QUARTERS_PER_CYCLE   4
`define HOLD_SHORT_QUARTERS  1
`define HOLD_LONG_QUARTERS   5
`define TOP_OF_SPACE         24'hffffff
`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

// ### port_control_pkg.sv
package port_control_pkg;
    // ----------------------------------------
    // transaction sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STROBE,
        ST_HOLD,
        ST_DATA
    } seq_state_t;
endpackage
